// [design/fbi_pkg.sv]
// Shared types and constants of the flash bus interface
package fbi_pkg;

   // -----------------------------------------------------------------
   // Widths
   // -----------------------------------------------------------------
   localparam int ADDR_W   = 21;
   localparam int DATA_W   = 16;
   localparam int PIN_W    = 5;
   localparam int CNT_W    = 4;
   localparam int LP_CNT_W = 5;

   // -----------------------------------------------------------------
   // Control pin positions and idle levels
   // -----------------------------------------------------------------
   localparam int PIN_CE  = 4;
   localparam int PIN_OE  = 3;
   localparam int PIN_WE  = 2;
   localparam int PIN_LE  = 1;
   localparam int PIN_CLK = 0;
   localparam logic [PIN_W-1:0] PINS_IDLE = 5'h1E;

   // -----------------------------------------------------------------
   // Configuration values
   // -----------------------------------------------------------------
   localparam logic [DATA_W-1:0] CFG_RESET  = 16'h8000;
   localparam logic              RSEL_ASYNC = 1'h1;
   localparam logic              EDGE_RISE  = 1'h1;
   localparam logic              VR_EARLY   = 1'h1;
   localparam logic [2:0]        BLEN_8     = 3'h2;
   localparam logic [2:0]        BLEN_CONT  = 3'h7;
   localparam logic [CNT_W-1:0]  LAT_OFFSET = 4'h2;
   localparam logic [CNT_W-1:0]  WORDS_4    = 4'h3;
   localparam logic [CNT_W-1:0]  WORDS_8    = 4'h7;
   localparam logic [1:0]        PAGE_LAST  = 2'h3;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int LP_IDLE_NS    = 150;
   localparam logic [LP_CNT_W-1:0] LP_IDLE_CYC =
      LP_CNT_W'((LP_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic chip_sel_n;
      logic out_en_n;
      logic write_n;
      logic latch_n;
      logic burst_clk;
   } fbi_pins_t;

   typedef struct packed {
      logic       read_select_bit;
      logic       rsv_14;
      logic [2:0] initial_latency_field;
      logic       clk_div;
      logic       y_latency;
      logic       valid_indicator_timing_bit;
      logic       burst_type;
      logic       active_edge_select_bit;
      logic [2:0] rsv_5_3;
      logic [2:0] burst_len;
   } fbi_cfg_t;

   typedef enum logic [2:0] {B_IDLE, B_LAT, B_DATA, B_WAIT, B_END} fbi_bst_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } fbi_cmd_t;

   typedef struct packed {
      logic [PIN_W-1:0] prev;
   } fbi_edge_st_t;

   typedef struct packed {
      logic [LP_CNT_W-1:0] cnt;
      logic                idle;
   } fbi_tmr_st_t;

   typedef struct packed {
      fbi_bst_t          bst;
      fbi_cfg_t          cfg;
      logic [ADDR_W-1:0] addr_prev;
      logic [DATA_W-1:0] data_prev;
      logic              wa_valid;
      logic [ADDR_W-1:0] wa;
      logic              cmd_write;
      fbi_cmd_t          cmd;
      logic [ADDR_W-1:0] async_addr;
      logic [ADDR_W-1:0] mem_addr;
      logic [CNT_W-1:0]  lat_cnt;
      logic [CNT_W-1:0]  words;
      logic              unaligned;
      logic [DATA_W-1:0] data_out;
      logic              data_oe;
      logic              ready_lvl;
      logic              ready_oe;
      logic              standby;
      logic              power_down;
      logic              core_sleep;
   } fbi_st_t;

   function automatic logic [CNT_W-1:0] fbi_lat_of(input logic [2:0] code);
      return {1'h0, code} + LAT_OFFSET;
   endfunction

endpackage

// [design/fbi_edge_det.sv]
// Rise and fall detector for the sampled control pins
`timescale 1ns/1ps
module fbi_edge_det import fbi_pkg::*; (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic [PIN_W-1:0] level,
   output logic      [PIN_W-1:0] rise,
   output logic      [PIN_W-1:0] fall
);
   fbi_edge_st_t st;
   fbi_edge_st_t next_st;

   always_comb begin
      next_st.prev = level;
   end

   // Idle levels at reset so that no false strobe edge appears after release
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st.prev <= PINS_IDLE;
      end else begin
         st <= next_st;
      end
   end

   genvar i;
   generate
      for (i = 0; i < PIN_W; i++) begin : g_pin
         assign rise[i] = level[i] & ~st.prev[i];
         assign fall[i] = ~level[i] & st.prev[i];
      end
   endgenerate
endmodule

// [design/fbi_idle_timer.sv]
// Bus idle timer that flags automatic low power
`timescale 1ns/1ps
module fbi_idle_timer import fbi_pkg::*; (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic enable,
   input  wire logic activity,
   output logic      idle
);
   fbi_tmr_st_t st;
   fbi_tmr_st_t next_st;

   always_comb begin
      next_st = st;
      if (!enable || activity) begin
         next_st.cnt  = '0;
         next_st.idle = 1'h0;
      end else if (st.cnt == LP_IDLE_CYC - 5'h01) begin
         next_st.idle = 1'h1;
      end else begin
         next_st.cnt = st.cnt + 5'h01;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign idle = st.idle;
endmodule

// [design/fbi_bus_if.sv]
// Device-side bus interface of a parallel x16 burst flash
// Function
// - Write address taken on first rising strobe
// - Write data taken on first chip/write rise
// - Burst clock ignored during writes
// - Output enable high floats data bus
// - Chip select high: standby, data bus floats
// - Program or erase continues through standby
// - Idle asynchronous bus enters automatic low power
// - Power-down pin low floats every output
// - Burst reads only when read select zero
// - Burst address on first active clock edge or latch rise
// - First burst data after configured latency
// - Burst data drivers on only with output enable; ready ignores it
// - Continuous burst walks the whole array
// - Unaligned continuous start pulls ready low
// - Ready timing chosen by configuration bit
// - Active burst clock edge chosen by bit
// - Read select one async, zero burst; resets one
// - Edge bit zero falling, one rising
// - Timing bit one pulls ready a cycle early
// - Latency codes two to six give four-eight
`timescale 1ns/1ps
module fbi_bus_if import fbi_pkg::*; (
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire fbi_pins_t         pins,
   input  wire logic              reset_powerdown_n,
   input  wire logic [ADDR_W-1:0] word_address_bus,
   input  wire logic [DATA_W-1:0] data_bus_in,
   output logic      [DATA_W-1:0] data_bus_out,
   output logic                   data_bus_oe,
   output logic                   ready_out,
   output logic                   ready_oe,
   output logic      [ADDR_W-1:0] mem_addr,
   input  wire logic [DATA_W-1:0] mem_rdata,
   output logic                   cmd_write,
   output fbi_cmd_t               cmd,
   input  wire logic              cfg_load,
   input  wire fbi_cfg_t          cfg_word,
   input  wire logic              pe_busy,
   output logic                   standby,
   output logic                   auto_low_power,
   output logic                   power_down,
   output logic                   core_sleep
);

   // -----------------------------------------------------------------
   // State and decode signals
   // -----------------------------------------------------------------
   fbi_st_t          st;
   fbi_st_t          next_st;
   logic [PIN_W-1:0] pin_rise;
   logic [PIN_W-1:0] pin_fall;
   logic             sync_mode;
   logic             act_edge;
   logic             in_write;
   logic             ce_active;
   logic             addr_edge;
   logic             data_edge;
   logic             burst_req;
   logic             latch_hit;
   logic             cont_burst;
   logic [CNT_W-1:0] words_last;
   logic             wait_next;
   logic             drive;
   logic             data_phase;
   logic             lp_enable;
   logic             bus_activity;

   function automatic logic [ADDR_W-1:0] next_word(input logic [ADDR_W-1:0] a,
                                                   input logic [2:0]        len);
      logic [ADDR_W-1:0] inc;
      inc = a + 21'h000001;
      if (len == BLEN_CONT) begin
         return inc;
      end
      if (len == BLEN_8) begin
         return {a[ADDR_W-1:3], inc[2:0]};
      end
      return {a[ADDR_W-1:2], inc[1:0]};
   endfunction

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   fbi_edge_det u_edge (
      .core_clk (core_clk),
      .rst      (rst),
      .level    (pins),
      .rise     (pin_rise),
      .fall     (pin_fall)
   );

   // Burst clock edges are excluded: the clock is unused in async modes
   assign bus_activity = (|pin_rise[PIN_W-1:PIN_LE]) || (|pin_fall[PIN_W-1:PIN_LE]) ||
                         (word_address_bus != st.addr_prev);
   assign lp_enable    = (st.cfg.read_select_bit == RSEL_ASYNC) && reset_powerdown_n &&
                         !pins.chip_sel_n;

   fbi_idle_timer u_idle (
      .core_clk (core_clk),
      .rst      (rst),
      .enable   (lp_enable),
      .activity (bus_activity),
      .idle     (auto_low_power)
   );

   // -----------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------
   always_comb begin
      next_st           = st;
      next_st.cmd_write = 1'h0;
      next_st.addr_prev = word_address_bus;
      next_st.data_prev = data_bus_in;
      sync_mode  = (st.cfg.read_select_bit != RSEL_ASYNC);
      act_edge   = (st.cfg.active_edge_select_bit == EDGE_RISE) ?
                   pin_rise[PIN_CLK] : pin_fall[PIN_CLK];
      in_write   = !pins.write_n || pin_rise[PIN_WE];
      ce_active  = !pins.chip_sel_n || pin_rise[PIN_CE];
      addr_edge  = pin_rise[PIN_CE] || pin_rise[PIN_WE] || pin_rise[PIN_LE];
      data_edge  = pin_rise[PIN_CE] || pin_rise[PIN_WE];
      burst_req  = sync_mode && !pins.chip_sel_n && pins.write_n &&
                   reset_powerdown_n;
      latch_hit  = (act_edge && !pins.latch_n) || pin_rise[PIN_LE];
      cont_burst = (st.cfg.burst_len == BLEN_CONT);
      words_last = (st.cfg.burst_len == BLEN_8) ? WORDS_8 : WORDS_4;
      wait_next  = st.unaligned && (st.mem_addr[1:0] == PAGE_LAST);

      // Writes look only at the strobes, never at the burst clock
      if (reset_powerdown_n && in_write && ce_active) begin
         // Address value is the one present just before the strobe rose
         if (addr_edge && !st.wa_valid) begin
            next_st.wa_valid = 1'h1;
            next_st.wa       = st.addr_prev;
         end
         if (data_edge) begin
            next_st.cmd_write = 1'h1;
            next_st.cmd.addr  = st.wa_valid ? st.wa : st.addr_prev;
            next_st.cmd.data  = st.data_prev;
            next_st.wa_valid  = 1'h0;
         end
      end

      case (st.bst)
         B_IDLE: begin
            if (burst_req && latch_hit) begin
               next_st.bst       = B_LAT;
               next_st.mem_addr  = (act_edge && !pins.latch_n) ?
                                   word_address_bus : st.addr_prev;
               next_st.lat_cnt   = fbi_lat_of(st.cfg.initial_latency_field) - 4'h1;
               next_st.words     = '0;
               next_st.unaligned = cont_burst && (next_st.mem_addr[1:0] != 2'h0);
            end
         end
         B_LAT: begin
            if (act_edge) begin
               if (st.lat_cnt <= 4'h1) begin
                  next_st.bst = B_DATA;
               end else begin
                  next_st.lat_cnt = st.lat_cnt - 4'h1;
               end
            end
         end
         B_DATA: begin
            if (act_edge) begin
               if (wait_next) begin
                  // One extra wait edge at the first page crossing
                  next_st.bst       = B_WAIT;
                  next_st.unaligned = 1'h0;
               end else if (!cont_burst && st.words == words_last) begin
                  next_st.bst = B_END;
               end else begin
                  next_st.mem_addr = next_word(st.mem_addr, st.cfg.burst_len);
                  next_st.words    = st.words + 4'h1;
               end
            end
         end
         B_WAIT: begin
            if (act_edge) begin
               next_st.bst      = B_DATA;
               next_st.mem_addr = next_word(st.mem_addr, st.cfg.burst_len);
               next_st.words    = st.words + 4'h1;
            end
         end
         B_END: begin
            next_st.bst = B_END;
         end
         default: begin
            next_st.bst = B_IDLE;
         end
      endcase

      // A dropped chip select or a mode change kills the burst outright
      if (!burst_req) begin
         next_st.bst = B_IDLE;
      end

      // Asynchronous reads: latch is transparent while held low
      if (!sync_mode) begin
         if (!pins.latch_n) begin
            next_st.async_addr = word_address_bus;
         end
         next_st.mem_addr = pins.latch_n ? st.async_addr : word_address_bus;
      end

      // Host keeps output enable high in writes; write_n gating adds margin
      drive = !pins.out_en_n && !pins.chip_sel_n && pins.write_n &&
              reset_powerdown_n;
      data_phase = (next_st.bst == B_DATA) || (next_st.bst == B_WAIT) ||
                   (next_st.bst == B_END);
      next_st.data_oe  = drive && (!sync_mode || data_phase);
      next_st.data_out = mem_rdata;
      next_st.ready_lvl = 1'h0;
      next_st.ready_oe = burst_req &&
                         ((st.cfg.valid_indicator_timing_bit == VR_EARLY) ?
                          (st.bst == B_DATA && wait_next) :
                          (st.bst == B_WAIT));

      next_st.standby    = pins.chip_sel_n && reset_powerdown_n;
      next_st.power_down = !reset_powerdown_n;
      // Program or erase keeps full power even in standby
      next_st.core_sleep = (next_st.standby || auto_low_power) && !pe_busy;

      if (cfg_load && reset_powerdown_n) begin
         next_st.cfg = cfg_word;
      end

      if (!reset_powerdown_n) begin
         next_st.bst       = B_IDLE;
         next_st.cfg       = CFG_RESET;
         next_st.wa_valid  = 1'h0;
         next_st.cmd_write = 1'h0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st     <= '0;
         st.bst <= B_IDLE;
         st.cfg <= CFG_RESET;
      end else begin
         st <= next_st;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign data_bus_out = st.data_out;
   assign data_bus_oe  = st.data_oe;
   assign ready_out    = st.ready_lvl;
   assign ready_oe     = st.ready_oe;
   assign mem_addr     = st.mem_addr;
   assign cmd_write    = st.cmd_write;
   assign cmd          = st.cmd;
   assign standby      = st.standby;
   assign power_down   = st.power_down;
   assign core_sleep   = st.core_sleep;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   logic [CNT_W-1:0] hlp_edges;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hlp_edges <= '0;
      end else if (st.bst != B_LAT) begin
         hlp_edges <= '0;
      end else if (act_edge) begin
         hlp_edges <= hlp_edges + 4'h1;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_bursting;
      st.bst != B_IDLE;
   endsequence

   sequence s_floated;
      st.bst == B_IDLE && !data_bus_oe;
   endsequence

   a_wr_addr_take: assert property (
      (reset_powerdown_n && pin_rise[PIN_LE] && !pins.write_n && !pins.chip_sel_n &&
       !st.wa_valid && !pin_rise[PIN_CE] && !pin_rise[PIN_WE])
      |=> st.wa_valid && st.wa == $past(st.addr_prev))
      else $error("write address not captured on latch rise");

   a_wr_data_take: assert property (
      (reset_powerdown_n && pin_rise[PIN_WE] && !pins.chip_sel_n)
      |=> cmd_write && cmd.data == $past(st.data_prev))
      else $error("write data not captured on write strobe rise");

   a_wr_no_burst: assert property (
      (!pins.write_n && st.bst == B_IDLE) |=> st.bst == B_IDLE)
      else $error("burst started during a write");

   a_oe_float: assert property (pins.out_en_n |=> !data_bus_oe)
      else $error("data bus driven with output enable high");

   a_standby_float: assert property (
      (pins.chip_sel_n && reset_powerdown_n) |=> standby && !data_bus_oe && !ready_oe)
      else $error("standby did not float the bus");

   a_pe_keep_power: assert property ((pins.chip_sel_n && pe_busy) |=> !core_sleep)
      else $error("core slept during program or erase");

   a_lp_async_only: assert property (auto_low_power |-> $past(st.cfg.read_select_bit))
      else $error("low power entered outside async read mode");

   a_pd_float: assert property (
      !reset_powerdown_n |=> power_down && !data_bus_oe && !ready_oe && st.bst == B_IDLE)
      else $error("power-down left an output driven");

   a_sync_only: assert property ((st.cfg.read_select_bit == RSEL_ASYNC) |=> st.bst == B_IDLE)
      else $error("burst active in asynchronous read mode");

   a_burst_addr: assert property (
      (st.bst == B_IDLE && burst_req && act_edge && !pins.latch_n)
      |=> st.bst == B_LAT && st.mem_addr == $past(word_address_bus))
      else $error("burst address not latched on active edge");

   a_lat_exact: assert property (
      (st.bst == B_LAT && act_edge && burst_req &&
       hlp_edges == fbi_lat_of(st.cfg.initial_latency_field) - 4'h2) |=> st.bst == B_DATA)
      else $error("first burst data not at configured latency");

   a_lat_early: assert property (
      (st.bst == B_LAT && hlp_edges < fbi_lat_of(st.cfg.initial_latency_field) - 4'h2)
      |=> st.bst != B_DATA)
      else $error("burst data presented before latency elapsed");

   a_edge_sel: assert property (
      (st.bst == B_LAT && st.cfg.active_edge_select_bit == EDGE_RISE && pin_fall[PIN_CLK])
      |=> $stable(st.lat_cnt))
      else $error("latency counted on the inactive clock edge");

   a_abort_float: assert property (s_bursting ##0 pins.chip_sel_n |=> s_floated)
      else $error("chip select high did not abort the burst");

   a_ready_cont: assert property (ready_oe |-> $past(st.cfg.burst_len) == BLEN_CONT)
      else $error("ready pulled low outside continuous burst");

   a_ready_late: assert property (
      (st.bst == B_WAIT && !st.cfg.valid_indicator_timing_bit && burst_req) |=> ready_oe)
      else $error("ready not low on the invalid data edge");
endmodule

// [bench/fbi_host_model.sv]
// Host bus model that drives the flash control pins, address and write data
`timescale 1ns/1ps
module fbi_host_model import fbi_pkg::*; (
   input  wire logic              core_clk,
   output fbi_pins_t              pins,
   output logic      [ADDR_W-1:0] addr,
   output logic      [DATA_W-1:0] data
);
   initial begin
      pins = PINS_IDLE;
      addr = '0;
      data = '0;
   end
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic drive(input logic [PIN_W-1:0] p, input logic [ADDR_W-1:0] a);
      pins = p;
      addr = a;
   endtask
   // Burst clock toggles mid-write on purpose; a write must not care
   task automatic write_word(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                             input logic ce_first);
      addr = a;
      data = d;
      pins = 5'h08;
      step(1);
      pins.latch_n = 1'h1;
      pins.burst_clk = 1'h1;
      addr = ~a;
      step(2);
      if (ce_first) pins.chip_sel_n = 1'h1;
      else pins.write_n = 1'h1;
      step(1);
      // Released lines show the inverse, so a late capture is caught
      data = ~d;
      pins = PINS_IDLE;
      step(2);
   endtask
   task automatic kedge(input logic act);
      pins.burst_clk = act;
      step(2);
      pins.burst_clk = ~act;
      step(2);
   endtask
   task automatic burst_start(input logic [ADDR_W-1:0] a, input logic act);
      addr = a;
      pins = {4'h2, ~act};
      step(2);
      kedge(act);
      pins.latch_n = 1'h1;
      addr = ~a;
   endtask
endmodule

// [bench/test_fbi_bus_if.sv]
// Self-checking bench of the flash bus interface
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD %s expected %h seen %h", nm, e, g); end end
module test_fbi_bus_if import fbi_pkg::*;;
   logic              core_clk;
   logic              rst = 1'h1;
   logic              rp_n = 1'h1;
   logic              cfg_load = 1'h0;
   fbi_cfg_t          cfg_word = CFG_RESET;
   logic              pe_busy = 1'h0;
   fbi_pins_t         pins;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] data;
   logic [DATA_W-1:0] dq_out;
   logic              dq_oe;
   logic [ADDR_W-1:0] mem_addr;
   logic              cmd_write;
   fbi_cmd_t          cmd;
   fbi_cmd_t          last_cmd;
   logic              standby;
   logic              rdy_oe;
   logic              rdy_lvl;
   logic              alp;
   logic              pdown;
   logic              sleep;
   int                n_fail = 0;
   int                n_checks = 0;
   int                n_cmd = 0;
   int                cyc = 0;

   fbi_host_model fbi_host_model_inst (.core_clk(core_clk), .pins(pins), .addr(addr),
                                       .data(data));
   // Array model: each word is its address folded with a fixed pattern
   fbi_bus_if fbi_bus_if_inst (.core_clk(core_clk), .rst(rst), .pins(pins),
      .reset_powerdown_n(rp_n), .word_address_bus(addr), .data_bus_in(data),
      .data_bus_out(dq_out), .data_bus_oe(dq_oe), .ready_out(rdy_lvl), .ready_oe(rdy_oe),
      .mem_addr(mem_addr), .mem_rdata(mem_addr[DATA_W-1:0] ^ 16'hA5A5),
      .cmd_write(cmd_write), .cmd(cmd), .cfg_load(cfg_load), .cfg_word(cfg_word),
      .pe_busy(pe_busy), .standby(standby), .auto_low_power(alp), .power_down(pdown),
      .core_sleep(sleep));

   initial begin
      core_clk = 1'h0;
      forever #5 core_clk = ~core_clk;
   end
   // Whole run needs well under a thousand cycles; the ceiling leaves margin
   always @(posedge core_clk) begin
      cyc++;
      if (cmd_write === 1'h1) begin
         n_cmd++;
         last_cmd = cmd;
      end
      if (cyc == 3000) begin
         n_fail++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic t_async();
      fbi_host_model_inst.drive(5'h04, 21'h0ABCD5);
      cycles(2);
      `CHK("mem_addr", 21'h0ABCD5, mem_addr)
      `CHK("dq_oe", 1'h1, dq_oe)
      `CHK("dq_out", 16'hBCD5 ^ 16'hA5A5, dq_out)
      `CHK("alp", 1'h0, alp)
      cycles(20);
      `CHK("alp", 1'h1, alp)
      `CHK("dq_oe", 1'h1, dq_oe)
      fbi_host_model_inst.drive(5'h0C, 21'h0ABCD5);
      cycles(2);
      `CHK("dq_oe", 1'h0, dq_oe)
   endtask
   task automatic t_standby();
      pe_busy = 1'h1;
      fbi_host_model_inst.drive(5'h14, 21'h0);
      cycles(2);
      `CHK("standby", 1'h1, standby)
      `CHK("dq_oe", 1'h0, dq_oe)
      `CHK("sleep", 1'h0, sleep)
      pe_busy = 1'h0;
      cycles(2);
      `CHK("sleep", 1'h1, sleep)
   endtask
   task automatic t_write(input logic ce_first, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
      int n0;
      n0 = n_cmd;
      fbi_host_model_inst.write_word(a, d, ce_first);
      `CHK("n_cmd", n0 + 1, n_cmd)
      `CHK("cmd", {a, d}, last_cmd)
   endtask
   task automatic t_pdown();
      fbi_host_model_inst.drive(5'h04, 21'h3);
      cycles(2);
      rp_n = 1'h0;
      cycles(2);
      `CHK("pdown", 1'h1, pdown)
      `CHK("dq_oe", 1'h0, dq_oe)
      rp_n = 1'h1;
      fbi_host_model_inst.drive(PINS_IDLE, 21'h0);
      cycles(2);
   endtask
   task automatic t_burst(input logic act);
      logic [ADDR_W-1:0] a;
      a = 21'h12344;
      cfg_word = CFG_RESET;
      cfg_word.read_select_bit = 1'h0;
      cfg_word.initial_latency_field = 3'h2;
      cfg_word.active_edge_select_bit = act;
      cfg_word.burst_len = 3'h1;
      cfg_load = 1'h1;
      cycles(1);
      cfg_load = 1'h0;
      fbi_host_model_inst.burst_start(a, act);
      `CHK("mem_addr", a, mem_addr)
      fbi_host_model_inst.kedge(act);
      fbi_host_model_inst.kedge(act);
      `CHK("dq_oe", 1'h0, dq_oe)
      fbi_host_model_inst.kedge(act);
      `CHK("dq_oe", 1'h1, dq_oe)
      `CHK("dq_out", a[15:0] ^ 16'hA5A5, dq_out)
      fbi_host_model_inst.kedge(act);
      `CHK("dq_out", (a[15:0] + 16'h1) ^ 16'hA5A5, dq_out)
      fbi_host_model_inst.drive({4'h7, ~act}, 21'h0);
      cycles(2);
      `CHK("dq_oe", 1'h0, dq_oe)
      fbi_host_model_inst.drive({4'hA, ~act}, 21'h0);
      cycles(2);
      fbi_host_model_inst.drive({4'h2, ~act}, a);
      cycles(3);
      `CHK("dq_oe", 1'h0, dq_oe)
      fbi_host_model_inst.drive(PINS_IDLE, 21'h0);
      cycles(2);
   endtask
   // Start two words into a page so the first page crossing needs a wait edge
   task automatic t_cont(input logic vr);
      cfg_word.burst_len = BLEN_CONT;
      cfg_word.active_edge_select_bit = 1'h1;
      cfg_word.valid_indicator_timing_bit = vr;
      cfg_load = 1'h1;
      cycles(1);
      cfg_load = 1'h0;
      fbi_host_model_inst.burst_start(21'h12346, 1'h1);
      repeat (4) fbi_host_model_inst.kedge(1'h1);
      `CHK("rdy_oe", vr, rdy_oe)
      `CHK("rdy_lvl", 1'h0, rdy_lvl)
      fbi_host_model_inst.kedge(1'h1);
      `CHK("rdy_oe", ~vr, rdy_oe)
      `CHK("dq_out", 16'h2347 ^ 16'hA5A5, dq_out)
      fbi_host_model_inst.kedge(1'h1);
      `CHK("rdy_oe", 1'h0, rdy_oe)
      `CHK("dq_out", 16'h2348 ^ 16'hA5A5, dq_out)
      fbi_host_model_inst.drive(PINS_IDLE, 21'h0);
      cycles(2);
   endtask

   initial begin
      repeat (5) @(posedge core_clk);
      #1;
      rst = 1'h0;
      cycles(2);
      t_async();
      t_standby();
      t_write(1'h0, 21'h1F0F1, 16'hC3A5);
      t_write(1'h1, 21'h00E12, 16'h5A3C);
      t_pdown();
      t_burst(1'h1);
      t_burst(1'h0);
      t_cont(1'h1);
      t_cont(1'h0);
      end_of_test();
   end
endmodule
